/* design/input_blocker.sv */
`timescale 1ns/10ps
`default_nettype none

// Per-signal blocking toward the logic input bus
module input_blocker #(
	parameter int         W    = 6,
	parameter logic [W-1:0] IDLE = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [W-1:0] sig_in,
	input  wire logic [W-1:0] block,
	output logic      [W-1:0] sig_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] gated;          // Registered bus image
	} blk_state_t;

	blk_state_t   state_reg;
	blk_state_t   state_next;
	logic [W-1:0] gated_next;         // Per-bit next value

	// Width guard
	if (W < 1) begin : g_chk
		$error("input_blocker width must be at least one");
	end

	// One gate per bus input
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign gated_next[i] = block[i] ? IDLE[i] : sig_in[i];
	end

	// Fill next image
	always_comb begin
		state_next       = state_reg;
		state_next.gated = gated_next;
	end

	// Reset to idle levels so no edge at release
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg.gated <= IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sig_out = state_reg.gated;

endmodule

`default_nettype wire

/* design/pld_power_input_gating.sv */
// Our own choices: the strobed register port and the placing of the registers.
`include "pld_gating_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pld_power_input_gating #(
	parameter int ARRAY_W   = `ARRAY_W,   // Logic array result width
	parameter bit LOW_VOLT  = 1'b0        // Selects the 100 ns quiet time; both settings round to 2 clocks
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	// Register port
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	// Processor bus strobes, on the system clock
	input  wire pld_gating_pkg::bus_strobe_t cpu_strobes,
	// Raw decode hits from the decode array
	input  wire pld_gating_pkg::mem_select_t decode_hits,
	// Device pins
	input  wire logic                       port_d_pin_2,
	input  wire logic                       port_c_pin_7,
	input  wire logic                       common_clock_in,
	// Power-down state from the power-down unit
	input  wire logic                       powerdown_active,
	// Logic array evaluation result
	input  wire logic [ARRAY_W-1:0]         array_result,
	// Outputs
	output pld_gating_pkg::mem_select_t     mem_selects,
	output pld_gating_pkg::bus_strobe_t     mem_strobes,
	output logic      [`LBUS_W-1:0]         logic_input_bus,
	output logic      [ARRAY_W-1:0]         array_out,
	output logic                            array_standby,
	output logic                            macrocell_clock,
	output logic                            powerdown_clock,
	output logic                            port_d_pin_2_gpio,
	output logic                            powerdown_wake
);

	// ----------------------------------------------------------------
	// Local constants
	// ----------------------------------------------------------------
	// Quiet time in whole clocks, rounded up:
	// standby never comes early, at most a clock late
	localparam int QUIET_CYC = LOW_VOLT ? `QUIET_CYC_3V3 : `QUIET_CYC_5V;
	// Four bits hold any count up to 15
	localparam int CNT_W     = 4;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Refuse what the logic cannot serve
	if (ARRAY_W < 1) begin : g_chk_w
		$error("array width must be at least one");
	end
	if (QUIET_CYC < 1 || QUIET_CYC > 15) begin : g_chk_q
		$error("quiet count does not fit its counter");
	end

	// ----------------------------------------------------------------
	// Whole module state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                 pmr0;          // power_mgmt_reg_0
		logic [7:0]                 pmr2;          // power_mgmt_reg_2
		logic                       msel_en;       // Select function assigned
		logic [7:0]                 rdata;         // Read answer
		pld_gating_pkg::arr_state_t arr;           // Array power state
		logic [CNT_W-1:0]           quiet_cnt;     // Cycles with no input change
		logic [`LBUS_W-1:0]         lbus_prev;     // Bus image one cycle back
		logic [ARRAY_W-1:0]         arr_out;       // Latched array outputs
		logic                       msel_prev;     // Select level one cycle back
		logic                       wake;          // Power-down wake pulse
		logic                       gpio;          // Ordinary pin image
		logic                       mc_clk;        // Macrocell clock image
		logic                       pd_clk;        // Counter clock image
		pld_gating_pkg::mem_select_t sel;          // Gated memory selects
		pld_gating_pkg::bus_strobe_t mstb;         // Strobes to memories
	} core_state_t;

	core_state_t state_reg;
	core_state_t state_next;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pins_sync;            // {clock, C7, select}
	logic       msel_n_s;             // Synchronised select, low active
	logic       portc7_s;             // Synchronised port C7
	logic       cclk_s;               // Synchronised common clock

	// Pins move at any time; all logic below
	// reads stage two, never the first flop
	// All pins cross in one bank
	sync2 #(
		.W (3)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.async_in ({common_clock_in, port_c_pin_7, port_d_pin_2}),
		.sync_out (pins_sync)
	);

	assign msel_n_s = pins_sync[0];
	assign portc7_s = pins_sync[1];
	assign cclk_s   = pins_sync[2];

	// ----------------------------------------------------------------
	// Logic input bus gating
	// ----------------------------------------------------------------
	logic [`LBUS_W-1:0] lbus_raw;     // Ungated bus inputs
	logic [`LBUS_W-1:0] lbus_block;   // Per-input block mask
	logic [`LBUS_W-1:0] lbus;         // Gated, registered bus

	assign lbus_raw = {cclk_s, portc7_s, cpu_strobes};

	assign lbus_block = {state_reg.pmr0[`PMR0_CLK_BLK_BUS_BIT],
	                     state_reg.pmr2[`PMR2_PORTC7_BLK_BIT],
	                     state_reg.pmr2[`PMR2_STROBE_HI_BIT:`PMR2_STROBE_LO_BIT]};

	// Idle, not last value: a release gives
	// one clean edge at most
	// Blocked bits sit at their idle level
	input_blocker #(
		.W    (`LBUS_W),
		.IDLE (`LBUS_IDLE)
	) u_blocker (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.sig_in  (lbus_raw),
		.block   (lbus_block),
		.sig_out (lbus)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Helpers, set at the top of the process
	logic lbus_change;                // Any unblocked bus edge
	logic turbo_off;                  // Non-turbo operation
	logic msel_ok;                    // Memories may be selected

	// Registers, select gate, clock images and
	// array power; one pass fills the next state
	always_comb begin
		state_next  = state_reg;
		lbus_change = (lbus != state_reg.lbus_prev);
		turbo_off   = state_reg.pmr0[`PMR0_TURBO_OFF_BIT];
		// select qualifies decode only when assigned
		msel_ok     = !state_reg.msel_en || !msel_n_s;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`PMR0_OFFSET: begin
					state_next.pmr0 = reg_wdata;
				end
				`PMR2_OFFSET: begin
					state_next.pmr2 = reg_wdata;
				end
				`MSEL_CFG_OFFSET: begin
					state_next.msel_en = reg_wdata[`MSEL_CFG_EN_BIT];
				end
				default: begin
					// Unmapped or read-only: ignored
					// Status writes are dropped here
				end
			endcase
		end

		// Read answer, valid the cycle after the strobe
		// Zero otherwise, so a late sample shows
		state_next.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`PMR0_OFFSET: begin
					state_next.rdata = state_reg.pmr0;
				end
				`PMR2_OFFSET: begin
					state_next.rdata = state_reg.pmr2;
				end
				`MSEL_CFG_OFFSET: begin
					state_next.rdata = {7'h00, state_reg.msel_en};
				end
				`STATUS_OFFSET: begin
					state_next.rdata = {4'h0, powerdown_active, msel_n_s,
					                    state_reg.arr};
				end
				default: begin
					// Unmapped reads return zero
					state_next.rdata = 8'h00;
				end
			endcase
		end

		// select high forces every select off when the select function is assigned
		state_next.sel = msel_ok ? decode_hits : '0;

		state_next.mstb = cpu_strobes;

		// pin reads as ordinary input when unassigned
		// select level never reaches logic or pins
		state_next.gpio = state_reg.msel_en ? 1'b0 : msel_n_s;

		// Previous level resets high: no false wake
		// falling select edge ends power-down
		state_next.msel_prev = msel_n_s;
		state_next.wake      = state_reg.msel_en && powerdown_active &&
		                       state_reg.msel_prev && !msel_n_s;

		// Hazard: sampled clock images, not clock
		// nets; users treat them as data
		// macrocell clock blocked alone
		state_next.mc_clk = cclk_s && !state_reg.pmr0[`PMR0_CLK_BLK_MC_BIT];
		state_next.pd_clk = cclk_s;

		// Quiet tracking on the gated bus
		// Saturates; any bus edge restarts it
		state_next.lbus_prev = lbus;
		if (lbus_change) begin
			state_next.quiet_cnt = '0;
		end else if (state_reg.quiet_cnt != CNT_W'(QUIET_CYC)) begin
			state_next.quiet_cnt = state_reg.quiet_cnt + CNT_W'(1);
		end

		// Array power state
		case (state_reg.arr)
			pld_gating_pkg::ARR_ACTIVE: begin
				state_next.arr_out = array_result;
				if (turbo_off && !lbus_change) begin
					state_next.arr = pld_gating_pkg::ARR_SETTLE;
				end
			end
			pld_gating_pkg::ARR_SETTLE: begin
				state_next.arr_out = array_result;
				if (!turbo_off || lbus_change) begin
					state_next.arr = pld_gating_pkg::ARR_ACTIVE;
				// quiet long enough, latch and sleep
				end else if (state_reg.quiet_cnt + CNT_W'(1) >= CNT_W'(QUIET_CYC)) begin
					state_next.arr = pld_gating_pkg::ARR_STANDBY;
				end
			end
			pld_gating_pkg::ARR_STANDBY: begin
				// Outputs hold; array_result ignored
				// wake and evaluate on any edge
				if (lbus_change || !turbo_off) begin
					state_next.arr     = pld_gating_pkg::ARR_ACTIVE;
					state_next.arr_out = array_result;
				end
			end
			default: begin
				// Illegal code recovers to active
				state_next.arr = pld_gating_pkg::ARR_ACTIVE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset; turbo stays on after reset
	// Reset branch holds constants only
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg.pmr0      <= `PMR0_RESET;
			state_reg.pmr2      <= `PMR2_RESET;
			state_reg.msel_en   <= `MSEL_CFG_RESET;
			state_reg.rdata     <= 8'h00;
			state_reg.arr       <= pld_gating_pkg::ARR_ACTIVE;
			state_reg.quiet_cnt <= '0;
			state_reg.lbus_prev <= `LBUS_IDLE;
			state_reg.arr_out   <= '0;
			// Idle high avoids a false wake edge at release
			state_reg.msel_prev <= 1'b1;
			state_reg.wake      <= 1'b0;
			state_reg.gpio      <= 1'b0;
			state_reg.mc_clk    <= 1'b0;
			state_reg.pd_clk    <= 1'b0;
			state_reg.sel       <= '0;
			state_reg.mstb      <= 4'h7;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Bus lag: the strobe sits one cycle ahead of memories; wait states
	// are firmware's concern when turbo is off.
	// extra bus wait is firmware's job
	// Register read port
	assign reg_rdata         = state_reg.rdata;

	// Memory side
	assign mem_selects       = state_reg.sel;
	assign mem_strobes       = state_reg.mstb;

	// Logic input bus and arrays
	assign logic_input_bus   = lbus;
	assign array_out         = state_reg.arr_out;
	assign array_standby     = (state_reg.arr == pld_gating_pkg::ARR_STANDBY);

	// Clock images
	assign macrocell_clock   = state_reg.mc_clk;
	assign powerdown_clock   = state_reg.pd_clk;

	// Pin image and wake pulse
	assign port_d_pin_2_gpio = state_reg.gpio;
	assign powerdown_wake    = state_reg.wake;

endmodule

`default_nettype wire

/* design/sync2.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser; only stage two is visible outside
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;           // First stage, read by stage two only
		logic [W-1:0] safe;           // Second stage
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// Width guard
	if (W < 1) begin : g_chk
		$error("sync2 width must be at least one");
	end

	// Shift one stage per edge
	always_comb begin
		state_next      = state_reg;
		state_next.meta = async_in;
		state_next.safe = state_reg.meta;
	end

	// Synchronous reset to zero
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.safe;

endmodule

`default_nettype wire

/* pkg/pld_gating_params.svh */
`ifndef PLD_GATING_PARAMS_SVH
`define PLD_GATING_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PMR0_OFFSET      8'hb0
`define PMR2_OFFSET      8'hb4
`define MSEL_CFG_OFFSET  8'hb8
`define STATUS_OFFSET    8'hbc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMR0_TURBO_OFF_BIT     3
`define PMR0_CLK_BLK_BUS_BIT   4
`define PMR0_CLK_BLK_MC_BIT    5
`define PMR2_STROBE_LO_BIT     2
`define PMR2_STROBE_HI_BIT     5
`define PMR2_PORTC7_BLK_BIT    6
`define MSEL_CFG_EN_BIT        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMR0_RESET       8'h00
`define PMR2_RESET       8'h00
`define MSEL_CFG_RESET   1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    50
`define QUIET_NS_5V      65
`define QUIET_NS_3V3     100
`define QUIET_CYC_5V     ((`QUIET_NS_5V + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUIET_CYC_3V3    ((`QUIET_NS_3V3 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Logic input bus layout, idle levels and array width
// ----------------------------------------------------------------
`define LBUS_W           6
`define LBUS_IDLE        6'h07
`define ARRAY_W          16

`endif

/* pkg/pld_gating_pkg.sv */
package pld_gating_pkg;

	// ----------------------------------------------------------------
	// Logic array power state, Gray along active-settle-standby
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ARR_ACTIVE  = 2'b00,
		ARR_SETTLE  = 2'b01,
		ARR_STANDBY = 2'b11
	} arr_state_t;

	// ----------------------------------------------------------------
	// Processor bus strobes, active low except address latch
	// ----------------------------------------------------------------
	typedef struct packed {
		logic addr_latch;             // Address latch strobe, high active
		logic program_fetch_strobe_n; // Program fetch strobe
		logic wr_n;                   // Write strobe
		logic rd_n;                   // Read strobe
	} bus_strobe_t;

	// ----------------------------------------------------------------
	// Memory selects out of the decode array
	// ----------------------------------------------------------------
	typedef struct packed {
		logic csr_space_select;       // Control register space
		logic sram_select;            // SRAM
		logic boot_flash_select;      // Boot flash
		logic main_flash_select;      // Main flash
	} mem_select_t;

endpackage

/* verif/cpu_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Processor bus strobes cycling through address latch, fetch, read and write phases
module cpu_bus_model (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire logic                        run,
	output var  pld_gating_pkg::bus_strobe_t strobes
);
	logic [2:0] cnt_reg; // Phase timer, two cycles per phase

	always_ff @(posedge clk_sys) begin
		if (!rstn || !run) begin
			cnt_reg <= 3'h0;
			strobes <= 4'h7;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
			case (cnt_reg[2:1])
				2'h0:    strobes <= 4'hf; // Address latch high
				2'h1:    strobes <= 4'h3; // Fetch low
				2'h2:    strobes <= 4'h6; // Read low
				default: strobes <= 4'h5; // Write low
			endcase
		end
	end
endmodule
`default_nettype wire

/* verif/pld_gating_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pld_gating_params.svh"

module pld_gating_monitor (
	input wire logic                        clk_sys,
	input wire logic                        rstn,
	input wire logic [7:0]                  reg_addr,
	input wire logic [7:0]                  reg_wdata,
	input wire logic                        reg_wr,
	input wire pld_gating_pkg::bus_strobe_t cpu_strobes,
	input wire pld_gating_pkg::mem_select_t decode_hits,
	input wire logic                        port_d_pin_2,
	input wire logic                        port_c_pin_7,
	input wire logic                        common_clock_in,
	input wire logic                        powerdown_active,
	input wire pld_gating_pkg::mem_select_t mem_selects,
	input wire pld_gating_pkg::bus_strobe_t mem_strobes,
	input wire logic [`LBUS_W-1:0]          logic_input_bus,
	input wire logic                        array_standby,
	input wire logic                        macrocell_clock,
	input wire logic                        powerdown_clock,
	input wire logic                        port_d_pin_2_gpio,
	input wire logic                        powerdown_wake
);
	// ----------------------------------------------------------------
	// Register shadow and uptime
	// ----------------------------------------------------------------
	logic [7:0] pm0_reg;  // Mirror of power register 0
	logic [7:0] pm2_reg;  // Mirror of power register 2
	logic       msel_reg; // Mirror of select enable
	logic [1:0] up_cnt;   // Edges since reset, pins valid at 3

	// Mirror writes; pin paths need three clean edges
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pm0_reg  <= 8'h00;
			pm2_reg  <= 8'h00;
			msel_reg <= 1'b0;
			up_cnt   <= 2'h0;
		end else begin
			if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
			if (reg_wr && reg_addr == `PMR0_OFFSET) pm0_reg <= reg_wdata;
			if (reg_wr && reg_addr == `PMR2_OFFSET) pm2_reg <= reg_wdata;
			if (reg_wr && reg_addr == `MSEL_CFG_OFFSET) msel_reg <= reg_wdata[0];
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_strobe_pass: assert property (up_cnt != 2'h0 |->
		mem_strobes == $past(cpu_strobes)) else $error("memory strobes differ from bus");
	a_strobe_block: assert property (up_cnt != 2'h0 |-> logic_input_bus[3:0] ==
		(($past(cpu_strobes) & ~$past(pm2_reg[5:2])) | (4'h7 & $past(pm2_reg[5:2]))))
		else $error("strobe blocking wrong");
	a_portc_block: assert property (up_cnt == 2'h3 |-> logic_input_bus[4] ==
		(!$past(pm2_reg[6]) && $past(port_c_pin_7, 3))) else $error("port c7 path wrong");
	a_clk_routes: assert property (up_cnt == 2'h3 |->
		powerdown_clock == $past(common_clock_in, 3) &&
		macrocell_clock == (!$past(pm0_reg[5]) && $past(common_clock_in, 3)) &&
		logic_input_bus[5] == (!$past(pm0_reg[4]) && $past(common_clock_in, 3)))
		else $error("common clock routing wrong");
	a_sel_unconfig: assert property (up_cnt != 2'h0 && !$past(msel_reg) |->
		mem_selects == $past(decode_hits)) else $error("selects gated while unassigned");
	a_sel_gated: assert property (up_cnt == 2'h3 && $past(msel_reg) |->
		mem_selects == ($past(port_d_pin_2, 3) ? 4'h0 : $past(decode_hits)))
		else $error("module select gating wrong");
	a_gpio_level: assert property (up_cnt == 2'h3 |-> port_d_pin_2_gpio ==
		(!$past(msel_reg) && $past(port_d_pin_2, 3))) else $error("pin input level wrong");
	a_wake_pulse: assert property (up_cnt == 2'h3 && $past(msel_reg) &&
		powerdown_active && $fell(port_d_pin_2) |-> ##[1:4] powerdown_wake)
		else $error("no wake after select fall");
	a_standby_entry: assert property ((pm0_reg[3] && $stable(logic_input_bus)) [*6] |->
		array_standby) else $error("arrays not in standby when quiet");
	a_standby_exit: assert property (array_standby && !$stable(logic_input_bus) |->
		##[0:2] !array_standby) else $error("arrays stayed in standby on change");
	a_turbo_on: assert property (!pm0_reg[3] |=> !array_standby)
		else $error("standby with turbo on");
endmodule

bind pld_power_input_gating pld_gating_monitor mon_u (
	.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .cpu_strobes(cpu_strobes), .decode_hits(decode_hits),
	.port_d_pin_2(port_d_pin_2), .port_c_pin_7(port_c_pin_7),
	.common_clock_in(common_clock_in), .powerdown_active(powerdown_active),
	.mem_selects(mem_selects), .mem_strobes(mem_strobes),
	.logic_input_bus(logic_input_bus), .array_standby(array_standby),
	.macrocell_clock(macrocell_clock), .powerdown_clock(powerdown_clock),
	.port_d_pin_2_gpio(port_d_pin_2_gpio), .powerdown_wake(powerdown_wake)
);
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pld_gating_params.svh"

module tb;
	typedef struct packed {
		logic       msel;
		logic       pin;
		logic [3:0] hits;
		logic [3:0] sel;
		logic       gpio;
	} row_t;

	logic                        clk_sys, rstn, reg_wr, reg_rd, run, got;
	logic [7:0]                  reg_addr, reg_wdata, reg_rdata;
	logic                        port_d_pin_2, port_c_pin_7, common_clock_in;
	logic                        powerdown_active, array_standby, macrocell_clock;
	logic                        powerdown_clock, port_d_pin_2_gpio, powerdown_wake;
	logic [15:0]                 array_result, array_out;
	logic [5:0]                  logic_input_bus;
	pld_gating_pkg::bus_strobe_t cpu_strobes, mem_strobes, s;
	pld_gating_pkg::mem_select_t decode_hits, mem_selects;
	int                          fail_count, compares, cycles;
	// Select gating cases: enable, pin, hits, selects, pin input
	row_t rows [4] = '{'{1'b0, 1'b1, 4'hf, 4'hf, 1'b1}, '{1'b0, 1'b0, 4'h6, 4'h6, 1'b0},
		'{1'b1, 1'b0, 4'h5, 4'h5, 1'b0}, '{1'b1, 1'b1, 4'hf, 4'h0, 1'b0}};

	pld_power_input_gating #(.ARRAY_W(16)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_strobes(cpu_strobes),
		.decode_hits(decode_hits), .port_d_pin_2(port_d_pin_2), .port_c_pin_7(port_c_pin_7),
		.common_clock_in(common_clock_in), .powerdown_active(powerdown_active),
		.array_result(array_result), .mem_selects(mem_selects), .mem_strobes(mem_strobes),
		.logic_input_bus(logic_input_bus), .array_out(array_out),
		.array_standby(array_standby), .macrocell_clock(macrocell_clock),
		.powerdown_clock(powerdown_clock), .port_d_pin_2_gpio(port_d_pin_2_gpio),
		.powerdown_wake(powerdown_wake));
	cpu_bus_model cpu_u (.clk_sys(clk_sys), .rstn(rstn), .run(run), .strobes(cpu_strobes));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		chk_vec({15'h0, g}, {15'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		@(negedge clk_sys);
		chk_vec({8'h0, reg_rdata}, {8'h0, e});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic final_report;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard, a little over a hundred cycles expected
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rstn, reg_wr, reg_rd, run, reg_addr, reg_wdata} = '0;
		{port_c_pin_7, common_clock_in, powerdown_active} = '0;
		{fail_count, compares} = '0;
		port_d_pin_2 = 1'b1;
		decode_hits  = 4'h0;
		array_result = 16'h1234;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_chk(`PMR0_OFFSET, 8'h00);
		rd_chk(`PMR2_OFFSET, 8'h00);
		rd_chk(`MSEL_CFG_OFFSET, 8'h00);
		wr(8'h20, 8'hff);
		rd_chk(8'h20, 8'h00);
		wr(`PMR2_OFFSET, 8'h7c);
		rd_chk(`PMR2_OFFSET, 8'h7c);
		wr(`PMR0_OFFSET, 8'h38);
		rd_chk(`PMR0_OFFSET, 8'h38);
		$display("test registers done");
		// All logic bus inputs blocked while the bus runs
		port_c_pin_7    <= 1'b1;
		common_clock_in <= 1'b1;
		run             <= 1'b1;
		settle(4);
		repeat (8) begin
			s = cpu_strobes;
			@(negedge clk_sys);
			chk_vec({12'h0, mem_strobes}, {12'h0, s});
			chk_vec({10'h0, logic_input_bus}, {10'h0, `LBUS_IDLE});
			chk_bit(macrocell_clock, 1'b0);
			chk_bit(powerdown_clock, 1'b1);
		end
		wr(`PMR2_OFFSET, 8'h00);
		wr(`PMR0_OFFSET, 8'h00);
		settle(2);
		repeat (8) begin
			s = cpu_strobes;
			@(negedge clk_sys);
			chk_vec({12'h0, logic_input_bus[3:0]}, {12'h0, s});
			chk_vec({14'h0, logic_input_bus[5:4]}, 16'h0003);
			chk_bit(macrocell_clock, 1'b1);
		end
		run <= 1'b0;
		$display("test blocking done");
		for (int i = 0; i < 4; i++) begin
			wr(`MSEL_CFG_OFFSET, {7'h0, rows[i].msel});
			port_d_pin_2 <= rows[i].pin;
			decode_hits  <= rows[i].hits;
			settle(4);
			chk_vec({12'h0, mem_selects}, {12'h0, rows[i].sel});
			chk_bit(port_d_pin_2_gpio, rows[i].gpio);
			chk_vec({10'h0, logic_input_bus}, 16'h0037);
		end
		$display("test select table done");
		// Falling select while powered down
		powerdown_active <= 1'b1;
		settle(4);
		port_d_pin_2 <= 1'b0;
		got = 1'b0;
		repeat (8) begin
			@(negedge clk_sys);
			if (powerdown_wake === 1'b1) got = 1'b1;
		end
		chk_bit(got, 1'b1);
		powerdown_active <= 1'b0;
		$display("test wake done");
		// Quiet inputs with turbo off, then a port c7 change
		wr(`PMR0_OFFSET, 8'h08);
		settle(8);
		chk_bit(array_standby, 1'b1);
		chk_vec(array_out, 16'h1234);
		rd_chk(`STATUS_OFFSET, 8'h03);
		array_result <= 16'habcd;
		settle(2);
		chk_vec(array_out, 16'h1234);
		port_c_pin_7 <= 1'b0;
		got = 1'b0;
		repeat (8) begin
			@(negedge clk_sys);
			if (array_standby === 1'b0) got = 1'b1;
		end
		chk_bit(got, 1'b1);
		chk_vec(array_out, 16'habcd);
		wr(`PMR0_OFFSET, 8'h00);
		settle(2);
		chk_bit(array_standby, 1'b0);
		$display("test standby done");
		// Mid-run reset clears the turbo bit
		wr(`PMR0_OFFSET, 8'h08);
		rstn <= 1'b0;
		settle(2);
		rstn <= 1'b1;
		rd_chk(`PMR0_OFFSET, 8'h00);
		chk_bit(array_standby, 1'b0);
		$display("test reset done");
		final_report();
	end
endmodule
`default_nettype wire
